/* hw/pwl_top.sv */
// top: pulse-width limit registers and pwm pulse enforcement
`timescale 1ns/1ps
module pwl_top (
  input  wire logic                 mclk_in,        // 20 MHz core clock
  input  wire logic                 rst_in,         // sync reset, active high
  input  wire pwl_pkg::pwl_cmd_type cmd_in,         // management register command
  input  wire logic                 pwm_req_in,     // loop's raw pwm demand
  input  wire logic                 surge_req_in,   // overshoot_reduction request pulse
  input  wire logic                 hold_en_in,     // dc_regulation_control hold enable
  input  wire logic [15:0]          ton_calc_in,    // calculated on-time in cycles
  output logic                      pwm_out,        // limited pwm to power stage
  output logic                      hold_allow_out, // dc loop may hold via period error
  output logic                      surge_act_out,  // overshoot_reduction in progress
  output logic [15:0]               rdata_out,      // register read data
  output logic                      rvalid_out      // read data valid pulse
);
  // ---- register file ----
  logic [15:0] lim_q, lim_d;   // pulse_width_limits
  logic [15:0] srg_q, srg_d;   // overshoot_reduction_timing
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;

  // register writes; masks keep reserved bits at zero
  always_comb begin
    lim_d    = lim_q;
    srg_d    = srg_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (cmd_in.wr && cmd_in.addr == pwl_pkg::ADDR_PULSE_LIMITS) begin
      lim_d = cmd_in.wdata & pwl_pkg::MASK_PULSE_LIMITS;
    end
    if (cmd_in.wr && cmd_in.addr == pwl_pkg::ADDR_SURGE_TIMING) begin
      srg_d = cmd_in.wdata & pwl_pkg::MASK_SURGE_TIMING;
    end
    if (cmd_in.rd) begin
      rvalid_d = 1'b1;
      unique case (cmd_in.addr)
        pwl_pkg::ADDR_PULSE_LIMITS: rdata_d = lim_q & pwl_pkg::MASK_PULSE_LIMITS;
        pwl_pkg::ADDR_SURGE_TIMING: rdata_d = srg_q & pwl_pkg::MASK_SURGE_TIMING;
        default:                    rdata_d = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // register state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lim_q    <= pwl_pkg::RESET_PULSE_LIMITS;
      srg_q    <= pwl_pkg::RESET_SURGE_TIMING;
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      lim_q    <= lim_d;
      srg_q    <= srg_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ---- field decode into cycle counts ----
  pwl_pkg::pwl_limits_type raw_lim;  // from live registers
  pwl_ns2cyc #(.FW(3)) u_minh (
    .field_in(lim_q[pwl_pkg::MINH_MSB:pwl_pkg::MINH_LSB]), .step_ns_in(16'(pwl_pkg::STEP_NS)),
    .offset_ns_in(16'h0000), .cycles_out(raw_lim.min_high));
  pwl_ns2cyc #(.FW(4)) u_minl (
    .field_in(lim_q[pwl_pkg::MINL_MSB:pwl_pkg::MINL_LSB]), .step_ns_in(16'(pwl_pkg::LOW_STEP_NS)),
    .offset_ns_in(16'(pwl_pkg::LOW_OFFSET_NS)), .cycles_out(raw_lim.min_low));
  pwl_ns2cyc #(.FW(4)) u_ont (
    .field_in(lim_q[pwl_pkg::ONT_MSB:pwl_pkg::ONT_LSB]), .step_ns_in(16'(pwl_pkg::STEP_NS)),
    .offset_ns_in(16'h0000), .cycles_out(raw_lim.on_thresh));
  pwl_ns2cyc #(.FW(6)) u_flr (
    .field_in(srg_q[pwl_pkg::FLOOR_MSB:pwl_pkg::FLOOR_LSB]), .step_ns_in(16'(pwl_pkg::STEP_NS)),
    .offset_ns_in(16'h0000), .cycles_out(raw_lim.surge_floor));
  pwl_ns2cyc #(.FW(8)) u_hld (
    .field_in(srg_q[pwl_pkg::HOLD_MSB:pwl_pkg::HOLD_LSB]), .step_ns_in(16'(pwl_pkg::STEP_NS)),
    .offset_ns_in(16'h0000), .cycles_out(raw_lim.surge_holdoff));

  // ---- pwm sequencer ----
  pwl_pkg::pwl_limits_type act_q, act_d;   // limits latched at cycle start
  pwl_pkg::pwl_state_type  st_q, st_d;
  logic [15:0] cnt_q, cnt_d;               // time since the last pwm edge or surge start, saturating
  logic [15:0] hold_q, hold_d;             // holdoff remaining since last surge
  logic        pwm_q, pwm_d;
  logic        allow_q, allow_d;
  logic        surge_q, surge_d;

  // sequencer next state; limits only reload on a rising edge so no pulse is cut
  always_comb begin
    act_d   = act_q;
    st_d    = st_q;
    cnt_d   = (cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001;
    hold_d  = (hold_q == 16'h0000) ? hold_q : hold_q - 16'h0001;
    pwm_d   = pwm_q;
    surge_d = 1'b0;
    unique case (st_q)
      pwl_pkg::PWL_LOW: begin
        if (surge_req_in && hold_q == 16'h0000) begin
          st_d    = pwl_pkg::PWL_SURGE;
          cnt_d   = 16'h0001;
          hold_d  = raw_lim.surge_holdoff;
          surge_d = 1'b1;
        end else if (pwm_req_in && cnt_q >= act_q.min_low) begin
          st_d  = pwl_pkg::PWL_HIGH;
          act_d = raw_lim;
          cnt_d = 16'h0001;
          pwm_d = 1'b1;
        end
      end
      pwl_pkg::PWL_HIGH: begin
        // high ends only once minimum width is met; surge waits for that too
        if ((!pwm_req_in || (surge_req_in && hold_q == 16'h0000)) && cnt_q >= act_q.min_high) begin
          st_d  = pwl_pkg::PWL_LOW;
          cnt_d = 16'h0001;
          pwm_d = 1'b0;
        end
      end
      pwl_pkg::PWL_SURGE: begin
        surge_d = 1'b1;
        pwm_d   = 1'b0;
        // floor and ordinary minimum low both apply
        if (cnt_q >= act_q.surge_floor && cnt_q >= act_q.min_low) begin
          st_d    = pwl_pkg::PWL_LOW;
          surge_d = 1'b0;
        end
      end
      default: begin
        st_d  = pwl_pkg::PWL_LOW;
        pwm_d = 1'b0;
      end
    endcase
    // hold via period error only when on-time reaches threshold
    allow_d = hold_en_in && (ton_calc_in >= act_q.on_thresh);
  end

  // sequencer registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      act_q   <= '0;
      st_q    <= pwl_pkg::PWL_LOW;
      cnt_q   <= 16'h0000;
      hold_q  <= 16'h0000;
      pwm_q   <= 1'b0;
      allow_q <= 1'b0;
      surge_q <= 1'b0;
    end else begin
      act_q   <= act_d;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      hold_q  <= hold_d;
      pwm_q   <= pwm_d;
      allow_q <= allow_d;
      surge_q <= surge_d;
    end
  end

  assign pwm_out        = pwm_q;
  assign hold_allow_out = allow_q;
  assign surge_act_out  = surge_q;
  assign rdata_out      = rdata_q;
  assign rvalid_out     = rvalid_q;

  // holdoff watch for the checks below: its own count from each surge start,
  // kept apart from the countdown that the sequencer relies on
  logic [15:0] gap_q, gap_d;     // cycles since the last surge began, saturating
  logic [15:0] need_q, need_d;   // holdoff in force at that start
  logic        armed_q, armed_d; // at least one surge seen

  // holdoff watch next values
  always_comb begin
    gap_d   = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
    need_d  = need_q;
    armed_d = armed_q;
    if (surge_d && !surge_q) begin
      gap_d   = 16'h0001; // the start edge counts as the first cycle
      need_d  = raw_lim.surge_holdoff;
      armed_d = 1'b1;
    end
  end

  // holdoff watch registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      gap_q   <= 16'h0000;
      need_q  <= 16'h0000;
      armed_q <= 1'b0;
    end else begin
      gap_q   <= gap_d;
      need_q  <= need_d;
      armed_q <= armed_d;
    end
  end

  // ---- assertions ----
  sequence s_fall;
    $fell(pwm_q);
  endsequence

  property p_resv_zero;
    @(posedge mclk_in) disable iff (rst_in)
      rvalid_q |-> (rdata_q[15:14] == 2'b00);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits read nonzero");

  property p_lim_resv;
    @(posedge mclk_in) disable iff (rst_in) (lim_q[15:11] == 5'h00) && (srg_q[15:14] == 2'b00);
  endproperty
  a_lim_resv: assert property (p_lim_resv) else $error("reserved bits stored");

  property p_hold_block;
    @(posedge mclk_in) disable iff (rst_in)
      (ton_calc_in < act_q.on_thresh) |=> !hold_allow_out;
  endproperty
  a_hold_block: assert property (p_hold_block) else $error("hold allowed below on-time threshold");

  property p_min_high;
    @(posedge mclk_in) disable iff (rst_in)
      s_fall |-> ($past(cnt_q) >= act_q.min_high);
  endproperty
  a_min_high: assert property (p_min_high) else $error("high pulse too short");

  property p_min_low;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(pwm_q) |-> ($past(cnt_q) >= $past(act_q.min_low));
  endproperty
  a_min_low: assert property (p_min_low) else $error("low time too short");

  property p_surge_low;
    @(posedge mclk_in) disable iff (rst_in) surge_q |-> !pwm_q;
  endproperty
  a_surge_low: assert property (p_surge_low) else $error("pwm high during surge");

  sequence s_surge_end;
    $fell(surge_q);
  endsequence

  property p_surge_floor;
    @(posedge mclk_in) disable iff (rst_in)
      s_surge_end |-> ($past(cnt_q) >= act_q.surge_floor);
  endproperty
  a_surge_floor: assert property (p_surge_floor) else $error("surge low shorter than floor");

  // a new surge start, with an earlier one to measure from
  sequence s_surge_start;
    $rose(surge_q) && $past(armed_q);
  endsequence

  property p_holdoff;
    @(posedge mclk_in) disable iff (rst_in)
      s_surge_start |-> ($past(gap_q) >= $past(need_q));
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("surge started inside holdoff");

  property p_latch_edge;
    @(posedge mclk_in) disable iff (rst_in) !$rose(pwm_q) |-> $stable(act_q);
  endproperty
  a_latch_edge: assert property (p_latch_edge) else $error("limits changed mid cycle");
endmodule // pwl_top

/* hw/pwl_pkg.sv */
// package: register map, field layout and timing constants for the pwm pulse-width limit block
package pwl_pkg;
  // register addresses on the management command port
  localparam logic [7:0]  ADDR_PULSE_LIMITS    = 8'h3F;
  localparam logic [7:0]  ADDR_SURGE_TIMING    = 8'h40;
  // writable masks; reserved bits ignore writes and read zero
  localparam logic [15:0] MASK_PULSE_LIMITS    = 16'h07FF;
  localparam logic [15:0] MASK_SURGE_TIMING    = 16'h3FFF;
  localparam logic [15:0] RESET_PULSE_LIMITS   = 16'h0000;
  localparam logic [15:0] RESET_SURGE_TIMING   = 16'h0000;
  // field positions
  localparam int ONT_LSB = 7;
  localparam int ONT_MSB = 10;
  localparam int MINH_LSB = 4;
  localparam int MINH_MSB = 6;
  localparam int MINL_LSB = 0;
  localparam int MINL_MSB = 3;
  localparam int FLOOR_LSB = 8;
  localparam int FLOOR_MSB = 13;
  localparam int HOLD_LSB = 0;
  localparam int HOLD_MSB = 7;
  // timing: a 5 ns step is shorter than the 50 ns clock, so counts round up to cycles
  localparam int CLK_PERIOD_NS   = 50;
  localparam int STEP_NS         = 5;
  localparam int LOW_STEP_NS     = 20;
  localparam int LOW_OFFSET_NS   = 15;
  localparam int CNT_W           = 16;
  // register write/read command carried as one struct
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pwl_cmd_type;
  // decoded limits in clock cycles
  typedef struct packed {
    logic [CNT_W-1:0] min_high;
    logic [CNT_W-1:0] min_low;
    logic [CNT_W-1:0] surge_floor;
    logic [CNT_W-1:0] surge_holdoff;
    logic [CNT_W-1:0] on_thresh;
  } pwl_limits_type;
  // pwm sequencer states
  typedef enum logic [1:0] {
    PWL_LOW  = 2'b00,
    PWL_HIGH = 2'b01,
    PWL_SURGE = 2'b10
  } pwl_state_type;
endpackage

/* hw/pwl_ns2cyc.sv */
// converter: time field in ns-per-step to whole clock cycles, rounded up
`timescale 1ns/1ps
module pwl_ns2cyc #(
  parameter int FW = 8  // field width
) (
  input  wire logic [FW-1:0]            field_in,
  input  wire logic [15:0]              step_ns_in,
  input  wire logic [15:0]              offset_ns_in,
  output logic      [pwl_pkg::CNT_W-1:0] cycles_out
);
  logic [31:0] ns_total;  // total time in ns
  logic [31:0] cyc_total; // whole cycles before narrowing
  // least times round up to whole cycles, zero stays zero
  always_comb begin
    ns_total   = 32'(field_in) * 32'(step_ns_in) + 32'(offset_ns_in);
    cyc_total  = (ns_total + 32'(pwl_pkg::CLK_PERIOD_NS - 1)) / 32'(pwl_pkg::CLK_PERIOD_NS);
    cycles_out = cyc_total[pwl_pkg::CNT_W-1:0]; // field sizes keep counts far below the cut
  end
endmodule // pwl_ns2cyc

/* test/pwl_stage_model.sv */
// power stage model: tracks the shortest high and low runs it is driven with
`timescale 1ns/1ps
module pwl_stage_model (
  input  wire logic        clk_in,       // core clock
  input  wire logic        clear_in,     // restart width tracking
  input  wire logic        pwm_in,       // gate drive from the controller
  output logic      [15:0] min_high_out, // shortest high run seen
  output logic      [15:0] min_low_out   // shortest low run seen
);
  logic [15:0] run_q;  // cycles at the current level
  logic        last_q; // level of the previous cycle
  logic        seen_q; // an edge seen, so runs are whole
  // the first run after clear is partial, so it is never scored
  always @(posedge clk_in) begin
    if (clear_in) begin
      run_q <= 16'h0001;
      last_q <= pwm_in;
      seen_q <= 1'b0;
      min_high_out <= 16'hFFFF;
      min_low_out <= 16'hFFFF;
    end else if (pwm_in === last_q) begin
      run_q <= run_q + 16'h0001;
    end else begin
      // a run just ended: score it against its level
      if (seen_q && last_q && run_q < min_high_out) min_high_out <= run_q;
      if (seen_q && !last_q && run_q < min_low_out) min_low_out <= run_q;
      run_q <= 16'h0001;
      last_q <= pwm_in;
      seen_q <= 1'b1;
    end
  end
endmodule // pwl_stage_model

/* test/pwl_top_tb.sv */
// testbench: register map, pulse limits, surge floor and holdoff
`timescale 1ns/1ps
module pwl_top_tb;
  logic                 mclk_in;        // 20 MHz clock
  logic                 rst_in;         // sync reset
  pwl_pkg::pwl_cmd_type cmd_in;         // register command
  logic                 pwm_req_in;     // raw pwm demand
  logic                 surge_req_in;   // surge request
  logic                 hold_en_in;     // hold enable
  logic [15:0]          ton_calc_in;    // on-time in cycles
  logic                 pwm_out;        // limited pwm
  logic                 hold_allow_out; // hold permitted
  logic                 surge_act_out;  // surge running
  logic [15:0]          rdata_out;      // read data
  logic                 rvalid_out;     // read strobe
  logic                 clear_q;        // model clear
  logic [15:0]          min_high;       // model result
  logic [15:0]          min_low;        // model result
  int                   miscompares;    // mismatches
  int                   cmp_count;      // comparisons
  int                   cyc;            // timeout count
  int                   r0, r1, len, bad;
  logic                 prev;
  // rows: addr, write value, expected read; max values stay for later tests
  localparam logic [39:0] ROWS [5] = '{
    {8'h3F, 16'h0000, 16'h0000}, {8'h40, 16'h0000, 16'h0000},
    {8'h41, 16'hFFFF, 16'h0000}, {8'h3F, 16'hFFFF, 16'h07FF},
    {8'h40, 16'hFFFF, 16'h3FFF}};
  pwl_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd_in), .pwm_req_in(pwm_req_in),
    .surge_req_in(surge_req_in), .hold_en_in(hold_en_in), .ton_calc_in(ton_calc_in),
    .pwm_out(pwm_out), .hold_allow_out(hold_allow_out), .surge_act_out(surge_act_out),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out));
  pwl_stage_model STAGE (.clk_in(mclk_in), .clear_in(clear_q), .pwm_in(pwm_out),
    .min_high_out(min_high), .min_low_out(min_low));
  // clock generator
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // hang guard: all tests need well under this many cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one write: request held for the single taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    cmd_in <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_in);
    cmd_in <= '0;
  endtask
  // one read, checked just after the taking edge, while the valid pulse stands
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_in);
    cmd_in <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk_in);
    cmd_in <= '0;
    #1;
    chk({15'h0000, rvalid_out}, 16'h0001);
    chk(rdata_out, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  initial begin
    {miscompares, cmp_count, cyc} = '0;
    {cmd_in, pwm_req_in, surge_req_in, hold_en_in, ton_calc_in, clear_q} = '0;
    rst_in = 1'b1;
    idle(10);
    rst_in <= 1'b0;
    // reset values read back as zero, pwm idle low
    rd(8'h3F, 16'h0000);
    rd(8'h40, 16'h0000);
    chk({15'h0000, pwm_out}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(ROWS[i][39:32], ROWS[i][31:16]);
      rd(ROWS[i][39:32], ROWS[i][15:0]);
    end
    $display("test register rows done");
    // warm-up pulse latches the limits, then hammer the demand
    idle(1);
    pwm_req_in <= 1'b1;
    idle(3);
    pwm_req_in <= 1'b0;
    clear_q <= 1'b1;
    idle(12);
    clear_q <= 1'b0;
    repeat (60) begin
      @(posedge mclk_in);
      pwm_req_in <= ~pwm_req_in;
    end
    // an even count of toggles leaves the demand low
    idle(12);
    chk(min_high, 16'h0001);
    chk(min_low, 16'h0007);
    chk({15'h0000, min_low != 16'hFFFF}, 16'h0001);
    $display("test pulse limits done");
    // threshold of 75 ns is 2 cycles
    hold_en_in <= 1'b1;
    ton_calc_in <= 16'h0001;
    idle(3);
    chk({15'h0000, hold_allow_out}, 16'h0000);
    ton_calc_in <= 16'h0002;
    idle(3);
    chk({15'h0000, hold_allow_out}, 16'h0001);
    hold_en_in <= 1'b0;
    idle(3);
    chk({15'h0000, hold_allow_out}, 16'h0000);
    $display("test hold threshold done");
    // low minimum down to one cycle, latched by one pulse, so the floor alone holds the surge
    wr(8'h3F, 16'h07F0);
    pwm_req_in <= 1'b1;
    idle(2);
    pwm_req_in <= 1'b0;
    idle(10);
    // floor 315 ns is 7 cycles, holdoff 1275 ns is 26 cycles
    {r0, r1, len, bad} = '0;
    prev = 1'b0;
    surge_req_in <= 1'b1;
    for (int i = 1; i <= 90; i++) begin
      @(posedge mclk_in);
      #1;
      if (surge_act_out === 1'b1 && pwm_out !== 1'b0) bad++;
      if (surge_act_out === 1'b1 && !prev && r0 == 0) r0 = i;
      else if (surge_act_out === 1'b1 && !prev && r1 == 0) r1 = i;
      if (surge_act_out === 1'b1 && r1 == 0) len++;
      prev = surge_act_out;
    end
    surge_req_in <= 1'b0;
    chk(16'(bad), 16'h0000);
    chk({15'h0000, len >= 7}, 16'h0001);
    chk({15'h0000, r1 > 0 && r1 - r0 >= 26}, 16'h0001);
    // surge arriving mid-pulse ends the high after its minimum, then runs
    @(posedge mclk_in);
    pwm_req_in <= 1'b1;
    idle(30);
    chk({15'h0000, pwm_out}, 16'h0001);
    surge_req_in <= 1'b1;
    idle(3);
    chk({14'h0000, surge_act_out, pwm_out}, 16'h0002);
    {pwm_req_in, surge_req_in} <= 2'b00;
    $display("test surge done");
    finish_test();
  end
endmodule // pwl_top_tb
